// *** hw/audio_serial_clock_config_monitor.sv ***
// register file, clock generator and clock monitor of the audio serial port
`timescale 1ns/1ps
module audio_serial_clock_config_monitor #(
    parameter int unsigned timeout = asp_clk_pkg::timeout_cycles
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    output logic [7:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic wb_sel_i,
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    output logic wb_ack_o,
    input wire logic bitclk_i,
    output logic bitclk_o,
    output logic bitclk_oe,
    input wire logic frame_sync_i,
    output logic frame_sync_o,
    output logic frame_sync_oe,
    input wire logic mclk_i,
    output logic root_is_mclk,
    output logic pll_enabled,
    output logic [2:0] mclk_ratio_code,
    output logic mclk_as_multiple,
    output logic irq
);
    // the idle limit must exceed the longest frame the monitor is meant to see
    if (timeout < 16) begin : g_bad_timeout
        $error("timeout too short");
    end

    asp_clk_pkg::master_cfg_t mcfg_reg;
    asp_clk_pkg::clock_src_t csrc_reg;
    asp_clk_pkg::mode_ctrl_t mode_reg;
    logic [7:0] sts_reg;
    logic [2:0] irq_sts_reg, irq_mask_reg;
    logic ack_reg;
    logic [7:0] rdata_reg;

    // synchronisers
    logic [1:0] bclk_s, fs_s;
    logic bclk_d, fs_d;
    always_ff @(posedge clk) begin
        if (rst) begin
            bclk_s <= 2'b00;
            fs_s <= 2'b00;
            bclk_d <= 1'b0;
            fs_d <= 1'b0;
        end else begin
            bclk_s <= {bclk_s[0], bitclk_i};
            fs_s <= {fs_s[0], frame_sync_i};
            bclk_d <= bclk_s[1];
            fs_d <= fs_s[1];
        end
    end
    wire bclk_rise = bclk_s[1] & ~bclk_d;
    wire fs_rise = fs_s[1] & ~fs_d;

    // bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire wr_en = bus_req & wb_we_i & wb_sel_i;
    wire hit_mcfg = wb_adr_i == asp_clk_pkg::master_cfg_off;
    wire hit_sts = wb_adr_i == asp_clk_pkg::monitor_sts_off;
    wire hit_csrc = wb_adr_i == asp_clk_pkg::clock_src_off;
    wire hit_mode = wb_adr_i == asp_clk_pkg::mode_ctrl_off;
    wire hit_isr = wb_adr_i == asp_clk_pkg::irq_status_off;
    wire hit_imsk = wb_adr_i == asp_clk_pkg::irq_mask_off;
    wire [7:0] rd_mux = hit_mcfg ? mcfg_reg :
        hit_sts ? sts_reg :
        hit_csrc ? csrc_reg :
        hit_mode ? mode_reg :
        hit_isr ? {5'h00, irq_sts_reg} :
        hit_imsk ? {5'h00, irq_mask_reg} : 8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            ack_reg <= bus_req;
            rdata_reg <= bus_req ? rd_mux : rdata_reg;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            mcfg_reg <= asp_clk_pkg::master_cfg_rst; // RULE12
            csrc_reg <= asp_clk_pkg::clock_src_rst; // RULE13
            mode_reg <= asp_clk_pkg::mode_ctrl_rst;
            irq_mask_reg <= 3'h0;
        end else if (wr_en) begin
            if (hit_mcfg) mcfg_reg <= wb_dat_i;
            // reserved bits kept at zero regardless of what is written
            if (hit_csrc) csrc_reg <= wb_dat_i & asp_clk_pkg::clock_src_wmask; // RULE11
            if (hit_mode) mode_reg <= wb_dat_i;
            if (hit_imsk) irq_mask_reg <= wb_dat_i[2:0];
        end
    end

    // mode decode
    wire master = mode_reg.controller_target_select;
    wire auto_cfg = ~mode_reg.auto_cfg_disable;
    wire slave_auto = ~master & auto_cfg;
    assign pll_enabled = ~(auto_cfg & mode_reg.auto_pll_disable); // RULE16
    assign root_is_mclk = slave_auto & mode_reg.auto_pll_disable
        & csrc_reg.pllless_slave_root_source; // RULE7
    assign mclk_as_multiple = auto_cfg & csrc_reg.master_clock_spec_mode; // RULE8
    assign mclk_ratio_code = csrc_reg.mclk_ratio; // RULE9
    assign bitclk_oe = master; // RULE15
    assign frame_sync_oe = master; // RULE15

    // master clock generator: half period of bit clock in clk cycles
    wire prog_ok = (mcfg_reg.frame_rate <= asp_clk_pkg::rate_max)
        & (mcfg_reg.bitclk_per_frame <= asp_clk_pkg::ratio_max);
    wire [11:0] gen_ratio = asp_clk_pkg::ratio_value(mcfg_reg.bitclk_per_frame); // RULE2
    wire [19:0] gen_rate = asp_clk_pkg::rate_hz(mcfg_reg.frame_rate,
        mode_reg.rate_family_select); // RULE1 RULE14
    wire [31:0] gen_bclk_hz = 32'(gen_rate) * 32'(gen_ratio);
    wire [31:0] half_div = (gen_bclk_hz == 32'd0) ? 32'd1 :
        32'(asp_clk_pkg::clk_hz) / (gen_bclk_hz * 32'd2);
    wire gen_run = master & prog_ok & ~mode_reg.clock_gate & ~slave_auto; // RULE3
    logic [31:0] div_reg;
    logic gbclk_reg, fs_reg;
    logic [11:0] bitcnt_reg;
    wire tick = div_reg + 32'd1 >= half_div;
    // frame sync changes on the chosen edge of the generated bit clock
    wire fs_edge = tick & (gbclk_reg ^ ~csrc_reg.invert_bitclk_for_frame_gen); // RULE10
    always_ff @(posedge clk) begin
        if (rst | ~gen_run) begin
            div_reg <= 32'd0;
            gbclk_reg <= 1'b0;
            fs_reg <= 1'b0;
            bitcnt_reg <= 12'h000;
        end else begin
            div_reg <= tick ? 32'd0 : div_reg + 32'd1;
            if (tick) gbclk_reg <= ~gbclk_reg;
            if (fs_edge) begin
                bitcnt_reg <= (bitcnt_reg + 12'h001 >= gen_ratio) ? 12'h000 : bitcnt_reg + 12'h001;
                fs_reg <= bitcnt_reg == 12'h000;
            end
        end
    end
    assign bitclk_o = gbclk_reg;
    assign frame_sync_o = fs_reg;

    // monitor: count bit clocks per frame and clk cycles per frame
    logic [11:0] mbits_reg;
    logic [31:0] mcyc_reg;
    logic [31:0] idle_reg;
    logic locked_reg;
    function automatic logic [3:0] ratio_code(input logic [11:0] n);
        logic [3:0] c;
        c = asp_clk_pkg::code_invalid;
        for (int i = 0; i <= 12; i++) begin
            if (asp_clk_pkg::ratio_value(4'(i)) == n) c = 4'(i);
        end
        return c;
    endfunction
    // rate within about 2 percent of a nominal value of either family
    function automatic logic [3:0] rate_code(input logic [31:0] cyc);
        logic [3:0] c;
        logic [31:0] hz;
        logic [31:0] nom;
        c = asp_clk_pkg::code_invalid;
        hz = (cyc == 32'd0) ? 32'd0 : 32'(asp_clk_pkg::clk_hz) / cyc;
        for (int i = 0; i <= 8; i++) begin
            for (int f = 0; f < 2; f++) begin
                nom = 32'(asp_clk_pkg::rate_hz(4'(i), f[0]));
                // wide products: a very short frame gives a large hz that would wrap
                if (64'(hz) * 64'd50 > 64'(nom) * 64'd49
                    && 64'(hz) * 64'd50 < 64'(nom) * 64'd51) c = 4'(i);
            end
        end
        return c;
    endfunction
    wire [3:0] det_ratio = ratio_code(mbits_reg);
    wire [3:0] det_rate = rate_code(mcyc_reg);
    wire lost = idle_reg >= 32'(timeout);
    wire [7:0] sts_next = lost ? asp_clk_pkg::monitor_sts_rst :
        (fs_rise & locked_reg) ? {det_rate, det_ratio} : sts_reg; // RULE4 RULE5 RULE17
    always_ff @(posedge clk) begin
        if (rst) begin
            mbits_reg <= 12'h000;
            mcyc_reg <= 32'd0;
            idle_reg <= 32'd0;
            locked_reg <= 1'b0;
            sts_reg <= asp_clk_pkg::monitor_sts_rst; // RULE6
        end else begin
            mcyc_reg <= fs_rise ? 32'd1 : mcyc_reg + 32'd1;
            mbits_reg <= fs_rise ? 12'(bclk_rise) : mbits_reg + 12'(bclk_rise);
            idle_reg <= (fs_rise | lost) ? 32'd0 : idle_reg + 32'd1;
            locked_reg <= lost ? 1'b0 : (fs_rise ? 1'b1 : locked_reg);
            sts_reg <= sts_next;
        end
    end

    // interrupts: set wins over write-one clear
    wire [2:0] irq_set = {lost & (sts_reg != asp_clk_pkg::monitor_sts_rst),
        sts_next[3:0] != sts_reg[3:0], sts_next[7:4] != sts_reg[7:4]};
    wire [2:0] irq_clr = (wr_en & hit_isr) ? wb_dat_i[2:0] : 3'h0;
    always_ff @(posedge clk) begin
        if (rst) irq_sts_reg <= 3'h0;
        else irq_sts_reg <= (irq_sts_reg & ~irq_clr) | irq_set;
    end
    assign irq = |(irq_sts_reg & irq_mask_reg);
endmodule // audio_serial_clock_config_monitor

// *** hw/asp_clk_pkg.sv ***
// constants, types and register map of the audio serial clock block
// Notes on behaviour
// [RULE1] master frame rate from rate code 0-8
// [RULE2] master bitclocks per frame from code 0-12
// [RULE3] slave auto mode ignores programmed rate, ratio
// [RULE4] detected rate status, 15 means invalid
// [RULE5] detected ratio status, 15 means invalid
// [RULE6] status register read-only, resets to all ones
// [RULE7] root source bit picks bitclk or mclk
// [RULE8] mclk given absolute or as frame multiple
// [RULE9] mclk ratio field, reset 384, eight codes
// [RULE10] invert bitclk for frame generation in master
// [RULE11] software writes zero to reserved source bits
// [RULE12] master config resets to 0x48
// [RULE13] clock source config resets to 0x10
// [RULE14] family bit picks 48k or 44.1k values
// [RULE15] controller select drives or receives clocks
// [RULE16] pll disable makes root source selection apply
// [RULE17] detected fields track activity, else invalid
package asp_clk_pkg;
    localparam logic [7:0] master_cfg_off = 8'h14;
    localparam logic [7:0] monitor_sts_off = 8'h15;
    localparam logic [7:0] clock_src_off = 8'h16;
    localparam logic [7:0] mode_ctrl_off = 8'h13;
    localparam logic [7:0] irq_status_off = 8'h18;
    localparam logic [7:0] irq_mask_off = 8'h19;
    localparam logic [7:0] master_cfg_rst = 8'h48;
    localparam logic [7:0] monitor_sts_rst = 8'hff;
    localparam logic [7:0] clock_src_rst = 8'h10;
    localparam logic [7:0] mode_ctrl_rst = 8'h00;
    localparam logic [7:0] clock_src_wmask = 8'hfa;
    localparam logic [3:0] code_invalid = 4'hf;
    localparam logic [3:0] rate_max = 4'h8;
    localparam logic [3:0] ratio_max = 4'hc;
    localparam int clk_hz = 100_000_000;
    localparam int timeout_us = 2000;
    localparam int timeout_cycles = timeout_us * (clk_hz / 1_000_000);
    // irq status bits
    localparam int irq_rate_chg = 0;
    localparam int irq_ratio_chg = 1;
    localparam int irq_lost = 2;
    typedef struct packed {
        logic [3:0] frame_rate;
        logic [3:0] bitclk_per_frame;
    } master_cfg_t;
    typedef struct packed {
        logic pllless_slave_root_source;
        logic master_clock_spec_mode;
        logic [2:0] mclk_ratio;
        logic rsvd2;
        logic invert_bitclk_for_frame_gen;
        logic rsvd0;
    } clock_src_t;
    typedef struct packed {
        logic controller_target_select;
        logic auto_cfg_disable;
        logic auto_pll_disable;
        logic clock_gate;
        logic rate_family_select;
        logic [2:0] master_clock_freq_select;
    } mode_ctrl_t;
    // bitclocks per frame for ratio code
    function automatic logic [11:0] ratio_value(input logic [3:0] code);
        logic [11:0] v;
        v = 12'h000;
        unique case (code)
            4'h0: v = 12'h010;
            4'h1: v = 12'h018;
            4'h2: v = 12'h020;
            4'h3: v = 12'h030;
            4'h4: v = 12'h040;
            4'h5: v = 12'h060;
            4'h6: v = 12'h080;
            4'h7: v = 12'h0c0;
            4'h8: v = 12'h100;
            4'h9: v = 12'h180;
            4'ha: v = 12'h200;
            4'hb: v = 12'h400;
            4'hc: v = 12'h800;
            default: v = 12'h000;
        endcase
        return v;
    endfunction
    // nominal frame rate in hz for rate code and family
    function automatic logic [19:0] rate_hz(input logic [3:0] code, input logic fam44);
        logic [19:0] b;
        b = fam44 ? 20'd7350 : 20'd8000;
        unique case (code)
            4'h0: rate_hz = b;
            4'h1: rate_hz = 20'(b * 2);
            4'h2: rate_hz = 20'(b * 3);
            4'h3: rate_hz = 20'(b * 4);
            4'h4: rate_hz = 20'(b * 6);
            4'h5: rate_hz = 20'(b * 12);
            4'h6: rate_hz = 20'(b * 24);
            4'h7: rate_hz = 20'(b * 48);
            4'h8: rate_hz = 20'(b * 96);
            default: rate_hz = 20'd0;
        endcase
    endfunction
endpackage

// *** tb/asp_clk_checker.sv ***
// bus handshake and register decode checks on the top-level ports
`timescale 1ns/1ps
module asp_clk_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic [7:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    input wire logic wb_ack_o,
    input wire logic bitclk_oe,
    input wire logic frame_sync_oe,
    input wire logic pll_enabled,
    input wire logic [2:0] mclk_ratio_code
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_oe_pair: assert property (bitclk_oe == frame_sync_oe)
        else $error("clock enables differ");
    chk_reset_slave: assert property ($fell(rst) |-> !bitclk_oe && !wb_ack_o)
        else $error("clocks driven after reset");
    chk_rsvd_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h16 |-> wb_dat_o[2] == 1'b0 && wb_dat_o[0] == 1'b0)
        else $error("reserved source bits read as one");
    chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> wb_dat_o == 8'h00)
        else $error("unmapped read not zero");
    chk_ratio_code: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h16 |=> mclk_ratio_code == $past(wb_dat_i[5:3]))
        else $error("mclk ratio code not taken from write");
    chk_pll_decode: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h13 && !wb_dat_i[6] |=> pll_enabled != $past(wb_dat_i[5]))
        else $error("pll enable not following disable bit");
endmodule // asp_clk_checker
bind audio_serial_clock_config_monitor asp_clk_checker chk_i (.clk, .rst, .wb_adr_i, .wb_dat_i,
    .wb_dat_o, .wb_we_i, .wb_stb_i, .wb_cyc_i, .wb_ack_o, .bitclk_oe, .frame_sync_oe,
    .pll_enabled, .mclk_ratio_code);

// *** tb/asp_link_model.sv ***
// far-end host model driving bit clock and frame sync in slave mode
`timescale 1ns/1ps
module asp_link_model #(
    parameter int ratio = 64
) (
    input wire logic run,
    output logic bitclk,
    output logic frame_sync
);
    // clock rests low between bursts; frame pulse is one bit wide
    initial begin
        bitclk = 1'b0;
        frame_sync = 1'b0;
        #3;
        forever begin
            frame_sync = 1'b0;
            if (run) begin
                for (int i = 0; i < ratio; i++) begin
                    frame_sync = (i == 0);
                    #80 bitclk = 1'b1;
                    #80 bitclk = 1'b0;
                end
            end else #80;
        end
    end
endmodule // asp_link_model

// *** tb/audio_serial_clock_config_monitor_tb_top.sv ***
// self-checking bench of the audio serial clock block
`timescale 1ns/1ps
module audio_serial_clock_config_monitor_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sel = 1'b1, mclk = 1'b0, run = 1'b0;
    logic [7:0] adr = 8'h00, wdat = 8'h00, q, rdat;
    logic ack, bc_o, bc_oe, fs_o, fs_oe, bc_m, fs_m, bc_w, fs_w, root, pll_en, mam, irq, fs_d, bc_d;
    logic [2:0] mrc;
    int num_errors = 0, tests_run = 0, bits = 0, last_bits = 0, cnt = 0, last_cnt = 0;
    int ph = 0;
    always #5 clk = ~clk;
    assign bc_w = bc_oe ? bc_o : bc_m;
    assign fs_w = fs_oe ? fs_o : fs_m;
    asp_link_model #(.ratio(64)) far (.run(run), .bitclk(bc_m), .frame_sync(fs_m));
    audio_serial_clock_config_monitor #(.timeout(2000)) dut (.clk(clk), .rst(rst),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel),
        .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_ack_o(ack), .bitclk_i(bc_w), .bitclk_o(bc_o),
        .bitclk_oe(bc_oe), .frame_sync_i(fs_w), .frame_sync_o(fs_o), .frame_sync_oe(fs_oe),
        .mclk_i(mclk), .root_is_mclk(root), .pll_enabled(pll_en), .mclk_ratio_code(mrc),
        .mclk_as_multiple(mam), .irq(irq));
    // bit clock rises and clk cycles in each generated frame
    always @(posedge clk) begin
        fs_d <= fs_o;
        bc_d <= bc_o;
        cnt <= cnt + 1;
        if (fs_o && !fs_d) begin
            last_bits <= bits;
            last_cnt <= cnt;
            ph <= int'(bc_o);
            bits <= int'(bc_o && !bc_d);
            cnt <= 1;
        end else if (bc_o && !bc_d) bits <= bits + 1;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, adr, we, wdat} <= {2'b11, a, w, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (n == 20) begin
            num_errors++;
            close_out();
        end
        @(negedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00);
        check(q, e);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_chk(8'h14, 8'h48);
        rd_chk(8'h15, 8'hff);
        rd_chk(8'h16, 8'h10);
        bus(8'h15, 1'b1, 8'h00);
        rd_chk(8'h15, 8'hff);
        bus(8'h00, 1'b1, 8'h5a);
        rd_chk(8'h00, 8'h00);
        bus(8'h16, 1'b1, 8'hfa);
        rd_chk(8'h16, 8'hfa);
        check(8'(mam), 8'h01);
        for (int i = 0; i < 8; i++) begin
            bus(8'h16, 1'b1, 8'(i << 3));
            check(8'(mrc), 8'(i));
        end
        bus(8'h13, 1'b1, 8'h20);
        bus(8'h16, 1'b1, 8'h80);
        check({6'h0, root, pll_en}, 8'h02);
        $display("register test done");
        bus(8'h13, 1'b1, 8'h80);
        for (int k = 0; k < 2; k++) begin
            bus(8'h16, 1'b1, (k == 0) ? 8'h10 : 8'h12);
            bus(8'h14, 1'b1, 8'h80 | 8'(2 * k));
            repeat (600) @(posedge clk);
            @(negedge clk);
            check(8'(last_bits), 8'(16 << k));
            check(8'(last_cnt > 125 && last_cnt < 136), 8'h01);
            check({6'h0, bc_oe, fs_oe}, 8'h03);
            check(8'(ph), (k == 0) ? 8'h01 : 8'h00);
        end
        $display("master test done");
        bus(8'h13, 1'b1, 8'h00);
        bus(8'h14, 1'b1, 8'hff);
        run <= 1'b1;
        repeat (3500) @(posedge clk);
        rd_chk(8'h15, 8'h54);
        check({6'h0, bc_oe, irq}, 8'h00);
        bus(8'h18, 1'b0, 8'h00);
        check(q & 8'h03, 8'h03);
        bus(8'h19, 1'b1, 8'h07);
        repeat (2) @(negedge clk);
        check(8'(irq), 8'h01);
        bus(8'h18, 1'b1, 8'h07);
        repeat (2) @(negedge clk);
        check(8'(irq), 8'h00);
        run <= 1'b0;
        repeat (2500) @(posedge clk);
        rd_chk(8'h15, 8'hff);
        check(8'(irq), 8'h01);
        $display("slave test done");
        close_out();
    end
endmodule // audio_serial_clock_config_monitor_tb_top
